/* File: rtl/tshf_axil_slv.sv */
// AXI4-Lite slave turning bus transfers into register requests
`timescale 1ns/1ps
`default_nettype none
module tshf_axil_slv (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	tshf_reg_if.slv          rg
);
	typedef struct packed {
		logic        aw_h;
		logic [7:0]  aw_a;
		logic        w_h;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic        bv;
		logic [1:0]  br;
		logic        ar_b;
		logic [7:0]  ar_a;
		logic        rv;
		logic [1:0]  rr;
		logic [31:0] rd;
		logic        wr_p;
		logic        rd_p;
	} tshf_slv_t;
	tshf_slv_t s_q, s_d;

	assign awready = !s_q.aw_h && !s_q.bv;
	assign wready  = !s_q.w_h && !s_q.bv;
	assign arready = !s_q.ar_b;

	always_comb begin
		s_d = s_q;
		s_d.wr_p = 1'b0;
		s_d.rd_p = 1'b0;
		if (awvalid && awready) begin
			s_d.aw_h = 1'b1;
			s_d.aw_a = awaddr;
		end
		if (wvalid && wready) begin
			s_d.w_h = 1'b1;
			s_d.wd  = wdata;
			s_d.ws  = wstrb;
		end
		if (s_q.aw_h && s_q.w_h) begin
			s_d.aw_h = 1'b0;
			s_d.w_h  = 1'b0;
			s_d.wr_p = tshf_pkg::addr_ok(s_q.aw_a);
			s_d.bv   = 1'b1;
			s_d.br   = tshf_pkg::addr_ok(s_q.aw_a) ? tshf_pkg::RESP_OKAY : tshf_pkg::RESP_SLVERR;
		end
		if (s_q.bv && bready) s_d.bv = 1'b0;
		if (arvalid && arready) begin
			s_d.ar_b = 1'b1;
			s_d.ar_a = araddr;
			s_d.rd_p = 1'b1;
		end
		if (rg.rd_ack) begin
			s_d.rv = 1'b1;
			s_d.rd = tshf_pkg::addr_ok(s_q.ar_a) ? rg.rdata : 32'h0000_0000;
			s_d.rr = tshf_pkg::addr_ok(s_q.ar_a) ? tshf_pkg::RESP_OKAY : tshf_pkg::RESP_SLVERR;
		end
		if (s_q.rv && rready) begin
			s_d.rv   = 1'b0;
			s_d.ar_b = 1'b0;
		end
		if (!aresetn) s_d = '0;
	end

	always_ff @(posedge aclk) begin
		s_q <= s_d;
	end

	assign bvalid   = s_q.bv;
	assign bresp    = s_q.br;
	assign rvalid   = s_q.rv;
	assign rresp    = s_q.rr;
	assign rdata    = s_q.rd;
	assign rg.wr    = s_q.wr_p;
	assign rg.waddr = s_q.aw_a;
	assign rg.wdata = s_q.wd;
	assign rg.wstrb = s_q.ws;
	assign rg.rd    = s_q.rd_p;
	assign rg.raddr = s_q.ar_a;
endmodule
`default_nettype wire

/* File: rtl/tshf_pkg.sv */
// Shared constants, types and helpers of the transmit header fields block
package tshf_pkg;
	// ------------------------------------------------------------------
	// Map
	// ------------------------------------------------------------------
	localparam int          NBUF        = 8;
	localparam int          ADDR_W      = 8;
	localparam logic [2:0]  IDX_ASYNC   = 3'h0;
	localparam logic [2:0]  IDX_VIDEO   = 3'h1;
	localparam logic [2:0]  IDX_CFG     = 3'h2;
	localparam int          IDX_LSB     = 2;
	localparam int          BUF_LSB     = 5;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// ------------------------------------------------------------------
	// Fields
	// ------------------------------------------------------------------
	localparam int          SRC_LSB     = 24;
	localparam int          DBS_LSB     = 16;
	localparam int          FN_LSB      = 14;
	localparam int          QPC_LSB     = 11;
	localparam int          SPH_BIT     = 10;
	localparam int          CFG_FN_LSB  = 4;
	localparam int          CFG_PCM_BIT = 8;
	localparam logic [3:0]  ST_ASYNC    = 4'h1;
	localparam logic [3:0]  ST_DVB      = 4'h6;
	localparam logic [7:0]  DBS_DVB     = 8'h06;
	localparam logic [7:0]  DBS_OTHER   = 8'h00;
	localparam logic [2:0]  QPC_VAL     = 3'h0;
	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [3:0]  TYPE_RST0   = ST_DVB;
	localparam logic [1:0]  FN_RST0     = 2'h3;
	localparam logic [7:0]  SPH_RST     = 8'h01;

	typedef struct packed {
		logic [7:0][3:0]  stype;
		logic [7:0][1:0]  fn;
		logic [7:0]       pcm;
		logic [7:0]       source_packet_header_flag;
		logic [7:0][7:0]  block_continuity_counter;
		logic [4:0]       src;
		logic             rd_pend;
		logic [2:0]       rd_idx;
		logic [2:0]       rd_buf;
		logic             hdr_pend;
		logic [2:0]       hdr_b;
		logic             hdr_v;
		logic             hdr_as;
		logic [31:0]      hdr_w;
		logic             rd_ack;
		logic [31:0]      rdata;
	} tshf_core_t;

	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		return a[BUF_LSB-1:IDX_LSB] <= IDX_CFG;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
		end
		return r;
	endfunction
endpackage

/* File: rtl/tshf_reg_if.sv */
// Register request carrier between the bus slave and the core
`timescale 1ns/1ps
`default_nettype none
interface tshf_reg_if;
	logic        wr;
	logic [7:0]  waddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        rd;
	logic [7:0]  raddr;
	logic        rd_ack;
	logic [31:0] rdata;
	modport slv (output wr, waddr, wdata, wstrb, rd, raddr, input rd_ack, rdata);
	modport core (input wr, waddr, wdata, wstrb, rd, raddr, output rd_ack, rdata);
endinterface
`default_nettype wire

/* File: rtl/tshf_top.sv */
// Transmit header word one fields for eight transmit buffers
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Async word bits 31:16 hold writable destination node, reset zero, sent in header.
// - Async word bits 15:0 hold upper destination offset, reset zero, sent in header.
// - Video word reserved bits 31:29 and 9:8 ignore writes, read zero.
// - Source node field 28:24 refreshed on each PHY register 0 transfer.
// - Block size field 23:16 follows stream type; DVB gives 6.
// - Bits 15:14 report fraction code: undivided, two, four, eight blocks.
// - Padding count in bits 13:11 is read only and zero.
// - Flag at bit 10 is writable unless per-cell header mode is set.
// - Continuity counter bits 7:0 read only, reset zero, sent in header.
// - Async word applies only when buffer stream type is 1.
module tshf_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        phy_reg0_valid,
	input  wire logic [4:0]  phy_node_id,
	input  wire logic        tx_done,
	input  wire logic [2:0]  tx_buf,
	input  wire logic [7:0]  tx_blocks,
	input  wire logic        hdr_req,
	input  wire logic [2:0]  hdr_buf,
	output logic             hdr_valid,
	output logic             hdr_async,
	output logic [31:0]      hdr_word
);
	// ------------------------------------------------------------------
	// Bus slave and async word store
	// ------------------------------------------------------------------
	tshf_reg_if rg ();
	tshf_pkg::tshf_core_t s_q, s_d;
	logic [31:0] mem_a;
	logic [31:0] mem_b;
	logic        mem_we;
	logic [2:0]  wbuf;
	logic [2:0]  widx;
	logic [31:0] cfg_new;

	tshf_axil_slv u_slv (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.rg      (rg.slv)
	);

	assign wbuf   = rg.waddr[7:tshf_pkg::BUF_LSB];
	assign widx   = rg.waddr[tshf_pkg::BUF_LSB-1:tshf_pkg::IDX_LSB];
	assign mem_we = rg.wr && (widx == tshf_pkg::IDX_ASYNC);

	tshf_word_mem #(
		.W     (32),
		.DEPTH (tshf_pkg::NBUF),
		.AW    (3)
	) u_mem (
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (mem_we),
		.waddr   (wbuf),
		.wstrb   (rg.wstrb),
		.wdata   (rg.wdata),
		.raddr_a (rg.raddr[7:tshf_pkg::BUF_LSB]),
		.rdata_a (mem_a),
		.raddr_b (hdr_buf),
		.rdata_b (mem_b)
	);

	// ------------------------------------------------------------------
	// Word builders
	// ------------------------------------------------------------------
	function automatic logic [7:0] dbs_of(input logic [3:0] t);
		return (t == tshf_pkg::ST_DVB) ? tshf_pkg::DBS_DVB : tshf_pkg::DBS_OTHER;
	endfunction

	function automatic logic [31:0] vword(input tshf_pkg::tshf_core_t s, input logic [2:0] b);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[tshf_pkg::SRC_LSB +: 5] = s.src;
		w[tshf_pkg::DBS_LSB +: 8] = dbs_of(s.stype[b]);
		w[tshf_pkg::FN_LSB +: 2]  = s.fn[b];
		w[tshf_pkg::QPC_LSB +: 3] = tshf_pkg::QPC_VAL;
		w[tshf_pkg::SPH_BIT]      = s.source_packet_header_flag[b];
		w[7:0]                    = s.block_continuity_counter[b];
		return w;
	endfunction

	function automatic logic [31:0] cword(input tshf_pkg::tshf_core_t s, input logic [2:0] b);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[3:0] = s.stype[b];
		w[tshf_pkg::CFG_FN_LSB +: 2] = s.fn[b];
		w[tshf_pkg::CFG_PCM_BIT]     = s.pcm[b];
		return w;
	endfunction

	// ------------------------------------------------------------------
	// Core state
	// ------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		cfg_new = tshf_pkg::merge(cword(s_q, wbuf), rg.wdata, rg.wstrb);
		s_d.rd_ack   = 1'b0;
		s_d.hdr_v    = 1'b0;
		s_d.rd_pend  = rg.rd;
		s_d.rd_idx   = rg.raddr[tshf_pkg::BUF_LSB-1:tshf_pkg::IDX_LSB];
		s_d.rd_buf   = rg.raddr[7:tshf_pkg::BUF_LSB];
		s_d.hdr_pend = hdr_req;
		s_d.hdr_b    = hdr_buf;
		if (phy_reg0_valid) begin
			s_d.src = phy_node_id;
		end
		if (tx_done) begin
			s_d.block_continuity_counter[tx_buf] = 8'(s_q.block_continuity_counter[tx_buf] + tx_blocks);
		end
		if (rg.wr && widx == tshf_pkg::IDX_VIDEO && rg.wstrb[1] && !s_q.pcm[wbuf]) begin
			s_d.source_packet_header_flag[wbuf] = rg.wdata[tshf_pkg::SPH_BIT];
		end
		if (rg.wr && widx == tshf_pkg::IDX_CFG) begin
			s_d.stype[wbuf] = cfg_new[3:0];
			s_d.fn[wbuf]    = cfg_new[tshf_pkg::CFG_FN_LSB +: 2];
			s_d.pcm[wbuf]   = cfg_new[tshf_pkg::CFG_PCM_BIT];
		end
		if (s_q.rd_pend) begin
			s_d.rd_ack = 1'b1;
			unique case (s_q.rd_idx)
				tshf_pkg::IDX_ASYNC: s_d.rdata = mem_a;
				tshf_pkg::IDX_VIDEO: s_d.rdata = vword(s_q, s_q.rd_buf);
				tshf_pkg::IDX_CFG:   s_d.rdata = cword(s_q, s_q.rd_buf);
				default:             s_d.rdata = 32'h0000_0000;
			endcase
		end
		if (s_q.hdr_pend) begin
			s_d.hdr_v  = 1'b1;
			s_d.hdr_as = (s_q.stype[s_q.hdr_b] == tshf_pkg::ST_ASYNC);
			s_d.hdr_w  = s_d.hdr_as ? mem_b : vword(s_q, s_q.hdr_b);
		end
		if (!aresetn) begin
			s_d          = '0;
			s_d.stype[0] = tshf_pkg::TYPE_RST0;
			s_d.fn[0]    = tshf_pkg::FN_RST0;
			s_d.source_packet_header_flag      = tshf_pkg::SPH_RST;
		end
	end

	always_ff @(posedge aclk) begin
		s_q <= s_d;
	end

	assign rg.rd_ack = s_q.rd_ack;
	assign rg.rdata  = s_q.rdata;
	assign hdr_valid = s_q.hdr_v;
	assign hdr_async = s_q.hdr_as;
	assign hdr_word  = s_q.hdr_w;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [7:0] block_continuity_counter_sel;
	logic [1:0] fn_sel;
	logic       sph_lock_wr;
	assign block_continuity_counter_sel    = s_q.block_continuity_counter[tx_buf];
	assign fn_sel      = s_q.fn[hdr_buf];
	assign sph_lock_wr = rg.wr && widx == tshf_pkg::IDX_VIDEO && s_q.pcm[wbuf];

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_SRC_UPD: assert property (
		phy_reg0_valid |=> s_q.src == $past(phy_node_id))
		else $error("source node not refreshed");

	AST_SRC_HDR: assert property (
		hdr_valid && !hdr_async |-> hdr_word[28:24] == $past(s_q.src))
		else $error("header source node mismatch");

	AST_BLOCK_CONTINUITY_COUNTER_ADV: assert property (
		tx_done |=> s_q.block_continuity_counter[$past(tx_buf)] == 8'($past(block_continuity_counter_sel) + $past(tx_blocks)))
		else $error("continuity counter did not advance");

	AST_HDR_ASYNC: assert property (
		hdr_req && s_q.stype[hdr_buf] == tshf_pkg::ST_ASYNC
		|-> ##2 hdr_valid && hdr_async)
		else $error("async header not selected");

	AST_HDR_RSV: assert property (
		hdr_valid && !hdr_async
		|-> hdr_word[31:29] == 3'h0 && hdr_word[9:8] == 2'h0 && hdr_word[13:11] == 3'h0)
		else $error("reserved or padding bits not zero");

	AST_DVB_DBS: assert property (
		hdr_req && s_q.stype[hdr_buf] == tshf_pkg::ST_DVB
		|-> ##2 hdr_valid && hdr_word[23:16] == 8'h06)
		else $error("DVB block size not 6");

	AST_FN_OUT: assert property (
		hdr_req && s_q.stype[hdr_buf] != tshf_pkg::ST_ASYNC && !rg.wr
		|-> ##2 hdr_word[15:14] == $past(fn_sel, 2))
		else $error("fraction code not reported");

	AST_SPH_LOCK: assert property (
		sph_lock_wr |=> $stable(s_q.source_packet_header_flag))
		else $error("locked flag changed by write");

	AST_RST_DEF: assert property (
		$past(!aresetn) |-> s_q.source_packet_header_flag == 8'h01 && s_q.block_continuity_counter == '0 && hdr_word == 32'h0)
		else $error("reset defaults wrong");

	AST_BLOCK_CONTINUITY_COUNTER_RO: assert property (
		rg.wr && !tx_done |=> $stable(s_q.block_continuity_counter))
		else $error("counter changed by write");

	AST_SPH_WR: assert property (
		rg.wr && widx == tshf_pkg::IDX_VIDEO && rg.wstrb[1] && !s_q.pcm[wbuf]
		|=> s_q.source_packet_header_flag[$past(wbuf)] == $past(rg.wdata[tshf_pkg::SPH_BIT]))
		else $error("unlocked flag not written");

	AST_RD_RSV: assert property (
		rg.rd_ack && s_q.rd_idx == tshf_pkg::IDX_VIDEO
		|-> rg.rdata[31:29] == 3'h0 && rg.rdata[9:8] == 2'h0 && rg.rdata[13:11] == 3'h0)
		else $error("video word reserved bits not zero");

	AST_RD_SRC: assert property (
		rg.rd_ack && s_q.rd_idx == tshf_pkg::IDX_VIDEO
		|-> rg.rdata[28:24] == $past(s_q.src))
		else $error("read source node mismatch");

	AST_RD_DBS: assert property (
		rg.rd_ack && s_q.rd_idx == tshf_pkg::IDX_VIDEO
		|-> rg.rdata[23:16] == (($past(s_q.stype[s_q.rd_buf]) == tshf_pkg::ST_DVB)
			? tshf_pkg::DBS_DVB : tshf_pkg::DBS_OTHER))
		else $error("read block size mismatch");

	AST_RD_BLOCK_CONTINUITY_COUNTER: assert property (
		rg.rd_ack && s_q.rd_idx == tshf_pkg::IDX_VIDEO
		|-> rg.rdata[7:0] == $past(s_q.block_continuity_counter[s_q.rd_buf]))
		else $error("read counter mismatch");

	AST_HDR_BLOCK_CONTINUITY_COUNTER: assert property (
		hdr_valid && !hdr_async |-> hdr_word[7:0] == $past(s_q.block_continuity_counter[s_q.hdr_b]))
		else $error("header counter mismatch");

	AST_HDR_SPH: assert property (
		hdr_valid && !hdr_async |-> hdr_word[10] == $past(s_q.source_packet_header_flag[s_q.hdr_b]))
		else $error("header flag mismatch");

	COV_SPH_LOCK: cover property (sph_lock_wr);
	COV_RD_VIDEO: cover property (rg.rd_ack && s_q.rd_idx == tshf_pkg::IDX_VIDEO);
	COV_HDR_ASYNC: cover property (hdr_valid && hdr_async);
	COV_HDR_VIDEO: cover property (hdr_valid && !hdr_async && hdr_word[23:16] == 8'h06);
	COV_BLOCK_CONTINUITY_COUNTER_WRAP: cover property (tx_done ##1 s_q.block_continuity_counter[$past(tx_buf)] < $past(block_continuity_counter_sel));
endmodule
`default_nettype wire

/* File: rtl/tshf_word_mem.sv */
// Per-buffer word store with byte enables and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module tshf_word_mem #(
	parameter int W     = 32,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic            aclk,
	input  wire logic            aresetn,
	input  wire logic            we,
	input  wire logic [AW-1:0]   waddr,
	input  wire logic [W/8-1:0]  wstrb,
	input  wire logic [W-1:0]    wdata,
	input  wire logic [AW-1:0]   raddr_a,
	output logic      [W-1:0]    rdata_a,
	input  wire logic [AW-1:0]   raddr_b,
	output logic      [W-1:0]    rdata_b
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [W-1:0]            ra;
		logic [W-1:0]            rb;
	} tshf_mem_t;
	tshf_mem_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.ra = s_q.mem[raddr_a];
		s_d.rb = s_q.mem[raddr_b];
		if (we) begin
			for (int i = 0; i < W/8; i++) begin
				if (wstrb[i]) s_d.mem[waddr][i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		if (!aresetn) s_d = '0;
	end

	always_ff @(posedge aclk) begin
		s_q <= s_d;
	end

	assign rdata_a = s_q.ra;
	assign rdata_b = s_q.rb;
endmodule
`default_nettype wire

/* File: test/transmit_header_fields_tb_top.sv */
// Self-checking bench of the transmit header fields block
`timescale 1ns/1ps
`default_nettype none
module transmit_header_fields_tb_top;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, hdr_req, hdr_valid, hdr_async;
	logic        phy_reg0_valid, tx_done;
	logic [7:0]  awaddr, araddr, tx_blocks;
	logic [31:0] wdata, rdata, hdr_word;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [4:0]  phy_node_id;
	logic [2:0]  tx_buf, hdr_buf;
	int          n_fail, n_checks;
	logic [31:0] hw;
	logic        ha;

	tshf_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .phy_reg0_valid(phy_reg0_valid), .phy_node_id(phy_node_id),
		.tx_done(tx_done), .tx_buf(tx_buf), .tx_blocks(tx_blocks), .hdr_req(hdr_req),
		.hdr_buf(hdr_buf), .hdr_valid(hdr_valid), .hdr_async(hdr_async),
		.hdr_word(hdr_word));
	tshf_phy_model i_phy (.aclk(aclk), .phy_reg0_valid(phy_reg0_valid),
		.phy_node_id(phy_node_id), .tx_done(tx_done), .tx_buf(tx_buf),
		.tx_blocks(tx_blocks));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Handshake inputs are sampled mid-cycle, settled, and acted on at the next edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] er);
		logic       ga, gw, gb, sa, sw, sb;
		logic [1:0] sr;
		ga = 1'b0;
		gw = 1'b0;
		gb = 1'b0;
		@(posedge aclk);
		awaddr <= a; wdata <= d; wstrb <= s;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (!gb) begin
			@(negedge aclk);
			sa = awready;
			sw = wready;
			sb = bvalid;
			sr = bresp;
			@(posedge aclk);
			if (!ga && sa) begin
				ga = 1'b1;
				awvalid <= 1'b0;
			end
			if (!gw && sw) begin
				gw = 1'b1;
				wvalid <= 1'b0;
			end
			if (sb) begin
				gb = 1'b1;
				bready <= 1'b0;
				chk(sr, er);
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic        ga, gr, sa, sv;
		logic [31:0] sd;
		logic [1:0]  sr;
		ga = 1'b0;
		gr = 1'b0;
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (!gr) begin
			@(negedge aclk);
			sa = arready;
			sv = rvalid;
			sd = rdata;
			sr = rresp;
			@(posedge aclk);
			if (!ga && sa) begin
				ga = 1'b1;
				arvalid <= 1'b0;
			end
			if (sv) begin
				gr = 1'b1;
				rready <= 1'b0;
				chk(sd, ed);
				chk(sr, er);
			end
		end
	endtask
	task automatic hdr(input logic [2:0] b);
		@(posedge aclk);
		hdr_req <= 1'b1; hdr_buf <= b;
		@(posedge aclk);
		hdr_req <= 1'b0; hdr_buf <= ~b;
		@(posedge aclk);
		#1;
		chk(hdr_valid, 1'b1);
		hw = hdr_word; ha = hdr_async;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		rd(8'h00, 32'h0000_0000, tshf_pkg::RESP_OKAY);
		rd(8'h04, 32'h0006_c400, tshf_pkg::RESP_OKAY);
		rd(8'h24, 32'h0000_0000, tshf_pkg::RESP_OKAY);
		$display("t_reset done");
	endtask
	task automatic t_async;
		wr(8'h20, 32'ha5c3_1234, 4'hf, tshf_pkg::RESP_OKAY);
		wr(8'h20, 32'hffff_ffff, 4'h3, tshf_pkg::RESP_OKAY);
		rd(8'h20, 32'ha5c3_ffff, tshf_pkg::RESP_OKAY);
		hdr(3'h1);
		chk(ha, 1'b0);
		wr(8'h28, 32'h0000_0001, 4'hf, tshf_pkg::RESP_OKAY);
		hdr(3'h1);
		chk(ha, 1'b1);
		chk(hw, 32'ha5c3_ffff);
		$display("t_async done");
	endtask
	task automatic t_video;
		wr(8'h24, 32'hffff_ffff, 4'hf, tshf_pkg::RESP_OKAY);
		rd(8'h24, 32'h0000_0400, tshf_pkg::RESP_OKAY);
		wr(8'h28, 32'h0000_0100, 4'hf, tshf_pkg::RESP_OKAY);
		wr(8'h24, 32'h0000_0000, 4'hf, tshf_pkg::RESP_OKAY);
		rd(8'h24, 32'h0000_0400, tshf_pkg::RESP_OKAY);
		wr(8'h28, 32'h0000_0000, 4'hf, tshf_pkg::RESP_OKAY);
		wr(8'h24, 32'h0000_0000, 4'hf, tshf_pkg::RESP_OKAY);
		rd(8'h24, 32'h0000_0000, tshf_pkg::RESP_OKAY);
		for (int f = 0; f < 4; f++) begin
			wr(8'h48, 32'h6 | (f << 4), 4'hf, tshf_pkg::RESP_OKAY);
			rd(8'h44, 32'h0006_0000 | (f << 14), tshf_pkg::RESP_OKAY);
		end
		$display("t_video done");
	endtask
	task automatic t_src;
		i_phy.node_xfer(5'h15);
		rd(8'h44, 32'h1506_c000, tshf_pkg::RESP_OKAY);
		i_phy.node_xfer(5'h0b);
		hdr(3'h2);
		chk(hw, 32'h0b06_c000);
		$display("t_src done");
	endtask
	task automatic t_count;
		i_phy.send(3'h3, 8'hc8);
		i_phy.send(3'h3, 8'hc8);
		i_phy.send(3'h4, 8'h01);
		rd(8'h64, 32'h0b00_0090, tshf_pkg::RESP_OKAY);
		hdr(3'h3);
		chk(hw[7:0], 8'h90);
		rd(8'h84, 32'h0b00_0001, tshf_pkg::RESP_OKAY);
		$display("t_count done");
	endtask
	task automatic t_unmapped;
		wr(8'h2c, 32'hffff_ffff, 4'hf, tshf_pkg::RESP_SLVERR);
		rd(8'h2c, 32'h0000_0000, tshf_pkg::RESP_SLVERR);
		rd(8'h20, 32'ha5c3_ffff, tshf_pkg::RESP_OKAY);
		$display("t_unmapped done");
	endtask

	// ------------------------------------------------------------------
	// Clock, reset, sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		n_fail = 0; n_checks = 0; aresetn = 1'b0;
		awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
		awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
		hdr_req = 1'b0; hdr_buf = 3'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_async;
		t_video;
		t_src;
		t_count;
		t_unmapped;
		wrap_up;
	end
	initial begin
		#200us;
		n_fail++;
		wrap_up;
	end
endmodule
`default_nettype wire

/* File: test/tshf_phy_model.sv */
// Physical layer stand-in: node id transfers and packet-sent reports
`timescale 1ns/1ps
`default_nettype none
module tshf_phy_model (
	input  wire logic       aclk,
	output logic            phy_reg0_valid,
	output logic [4:0]      phy_node_id,
	output logic            tx_done,
	output logic [2:0]      tx_buf,
	output logic [7:0]      tx_blocks
);
	initial begin
		phy_reg0_valid = 1'b0;
		phy_node_id    = 5'h0a;
		tx_done        = 1'b0;
		tx_buf         = 3'h5;
		tx_blocks      = 8'h5a;
	end
	// One register 0 transfer, then the id lines go stale
	task automatic node_xfer(input logic [4:0] id);
		@(posedge aclk);
		phy_reg0_valid <= 1'b1;
		phy_node_id    <= id;
		@(posedge aclk);
		phy_reg0_valid <= 1'b0;
		phy_node_id    <= ~id;
	endtask
	// One packet sent from a buffer
	task automatic send(input logic [2:0] b, input logic [7:0] n);
		@(posedge aclk);
		tx_done   <= 1'b1;
		tx_buf    <= b;
		tx_blocks <= n;
		@(posedge aclk);
		tx_done   <= 1'b0;
		tx_buf    <= ~b;
		tx_blocks <= ~n;
	endtask
endmodule
`default_nettype wire
